// ===== usbsof_top.sv
// usb frame number capture and endpoint fifo reset registers on ahb-lite
`timescale 1ns/1ns
`include "usbsof_defs.svh"

module usbsof_top (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // start of frame events
   input wire usbsof_pkg::usbsof_sof_t sof_in,
   // endpoint fifo clears and interrupt
   output logic [`USBSOF_EP_COUNT-1:0] ep_fifo_clear,
   output logic irq
);
   import usbsof_pkg::*;

   // =====================================================================
   // state
   usbsof_frame_t frm;
   usbsof_frame_t next_frm;
   usbsof_wr_t wr;
   usbsof_wr_t next_wr;
   logic [`USBSOF_EP_COUNT-1:0] next_ep_fifo_clear;
   logic [`USBSOF_IRQ_W-1:0] irq_stat;
   logic [`USBSOF_IRQ_W-1:0] next_irq_stat;
   logic [`USBSOF_IRQ_W-1:0] irq_mask;
   logic [`USBSOF_IRQ_W-1:0] next_irq_mask;
   logic [31:0] next_hrdata;
   logic next_irq;

   // =====================================================================
   // address phase decode
   logic take;
   logic take_rd;
   logic take_wr;
   logic [`USBSOF_IDX_W-1:0] idx;
   logic idx_hit;

   always_comb begin
      take = hsel & hready & htrans[1];
      take_rd = take & ~hwrite;
      take_wr = take & hwrite;
      idx = haddr[`USBSOF_IDX_W+1:2];
      idx_hit = (haddr[31:`USBSOF_IDX_W+2] == '0) & (haddr[1:0] == 2'h0);
   end

   // =====================================================================
   // data phase write strobes
   logic wr_ep;
   logic wr_mask;

   always_comb begin
      wr_ep = wr.pend & (wr.idx == `USBSOF_IDX_EP_RST);
      wr_mask = wr.pend & (wr.idx == `USBSOF_IDX_IRQ_MASK);
   end

   // =====================================================================
   // frame capture
   always_comb begin
      next_frm = frm;
      if (sof_in.frame_done) begin
         next_frm.frame_count_value = sof_in.frame;
         next_frm.frame_crc_good = sof_in.crc_ok;
         next_frm.frame_crc_bad = ~sof_in.crc_ok;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         frm <= '0;
      end else begin
         frm <= next_frm;
      end
   end

   // =====================================================================
   // interrupt status, mask and level output
   logic [`USBSOF_IRQ_W-1:0] irq_set;
   logic [`USBSOF_IRQ_W-1:0] irq_clr;

   always_comb begin
      irq_set = '0;
      irq_set[`USBSOF_IRQ_SOF_BIT] = sof_in.pid_seen;
      irq_set[`USBSOF_IRQ_CRC_BAD_BIT] = sof_in.frame_done & ~sof_in.crc_ok;
      irq_clr = '0;
      if (take_rd && idx_hit && idx == `USBSOF_IDX_IRQ_STAT) begin
         irq_clr = '1;
      end
      // set wins over a read clear in the same cycle
      next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
      next_irq_mask = irq_mask;
      if (wr_mask) begin
         next_irq_mask = hwdata[`USBSOF_IRQ_W-1:0];
      end
      next_irq = |(next_irq_stat & next_irq_mask);
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_stat <= `USBSOF_RST_IRQ;
         irq_mask <= `USBSOF_RST_IRQ;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         irq <= next_irq;
      end
   end

   // =====================================================================
   // endpoint fifo clears
   always_comb begin
      next_ep_fifo_clear = ep_fifo_clear;
      if (wr_ep) begin
         next_ep_fifo_clear = hwdata[`USBSOF_EP_COUNT-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ep_fifo_clear <= `USBSOF_RST_EP;
      end else begin
         ep_fifo_clear <= next_ep_fifo_clear;
      end
   end

   // =====================================================================
   // bus control and read data
   always_comb begin
      next_wr.pend = take_wr & idx_hit;
      next_wr.idx = idx;
      next_hrdata = hrdata;
      if (take_rd) begin
         next_hrdata = '0;
         if (idx_hit) begin
            case (idx)
               `USBSOF_IDX_FRAME_COUNT_VALUE_LO: begin
                  next_hrdata[`USBSOF_FRAME_COUNT_VALUE_LO_W-1:0] =
                     frm.frame_count_value[`USBSOF_FRAME_COUNT_VALUE_LO_W-1:0];
               end
               `USBSOF_IDX_FRAME_COUNT_VALUE_HI: begin
                  next_hrdata[`USBSOF_FRAME_COUNT_VALUE_HI_W-1:0] =
                     frm.frame_count_value[`USBSOF_FRAME_COUNT_VALUE_W-1:`USBSOF_FRAME_COUNT_VALUE_LO_W];
                  next_hrdata[`USBSOF_HI_CRC_GOOD_BIT] = frm.frame_crc_good;
                  next_hrdata[`USBSOF_HI_CRC_BAD_BIT] = frm.frame_crc_bad;
               end
               `USBSOF_IDX_EP_RST: begin
                  next_hrdata[`USBSOF_EP_COUNT-1:0] =
                     wr_ep ? hwdata[`USBSOF_EP_COUNT-1:0] : ep_fifo_clear;
               end
               `USBSOF_IDX_IRQ_STAT: begin
                  next_hrdata[`USBSOF_IRQ_W-1:0] = irq_stat | irq_set;
               end
               `USBSOF_IDX_IRQ_MASK: begin
                  next_hrdata[`USBSOF_IRQ_W-1:0] =
                     wr_mask ? hwdata[`USBSOF_IRQ_W-1:0] : irq_mask;
               end
               default: begin
                  next_hrdata = '0;
               end
            endcase
         end
      end
   end

   // =====================================================================
   // bus registers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wr <= '0;
         hrdata <= '0;
         hreadyout <= 1'b0;
         hresp <= 1'b0;
      end else begin
         wr <= next_wr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);

   a_ep_clear_write: assert property (
      wr_ep |=> ep_fifo_clear == $past(hwdata[`USBSOF_EP_COUNT-1:0]))
      else $error("fifo clear bits do not follow the write");

   a_reserved_bit_zero: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_EP_RST |=> hrdata[31:`USBSOF_EP_COUNT] == '0)
      else $error("reserved fifo reset bit read as one");

   a_crc_good_set: assert property (
      sof_in.frame_done && sof_in.crc_ok |=> frm.frame_crc_good && !frm.frame_crc_bad)
      else $error("crc good flag not set on good frame");

   a_crc_bad_set: assert property (
      sof_in.frame_done && !sof_in.crc_ok
      |=> frm.frame_crc_bad && irq_stat[`USBSOF_IRQ_CRC_BAD_BIT])
      else $error("crc bad flag not set on corrupted frame");

   a_flags_refresh: assert property (
      sof_in.frame_done |=> frm.frame_crc_good == $past(sof_in.crc_ok)
      && frm.frame_crc_bad == !$past(sof_in.crc_ok))
      else $error("crc flags not refreshed from the latest packet");

   a_sof_irq_early: assert property (
      sof_in.pid_seen && !sof_in.frame_done |=> irq_stat[0] && $stable(frm))
      else $error("start of frame event late or frame changed early");

   a_high_read: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_FRAME_COUNT_VALUE_HI && !sof_in.frame_done
      |=> hrdata[2:0] == frm.frame_count_value[10:8] && !hrdata[3])
      else $error("high frame register read wrong");

   a_low_read: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_FRAME_COUNT_VALUE_LO && !sof_in.frame_done
      |=> hrdata[7:0] == frm.frame_count_value[7:0] && hrdata[31:8] == '0)
      else $error("low frame register read wrong");

   a_frame_hold: assert property (
      !sof_in.frame_done |=> $stable(frm.frame_count_value))
      else $error("frame number changed without a packet");

   // =====================================================================
   // checks of the bus side
   a_ready_after_reset: assert property (
      !$past(reset) |-> hreadyout)
      else $error("bus not ready after reset");

   a_resp_okay: assert property (
      hresp == 1'b0)
      else $error("bus response not okay");

   a_hrdata_hold: assert property (
      !take_rd |=> $stable(hrdata))
      else $error("read data changed without a read");

   a_unmapped_zero: assert property (
      take_rd && !idx_hit |=> hrdata == '0)
      else $error("unmapped read not zero");

   a_ep_read: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_EP_RST && !wr_ep
      |=> hrdata[`USBSOF_EP_COUNT-1:0] == $past(ep_fifo_clear))
      else $error("fifo clear read wrong");

   a_fifo_hold: assert property (
      !wr_ep |=> $stable(ep_fifo_clear))
      else $error("fifo clear bits changed without a write");

   a_mask_write: assert property (
      wr_mask |=> irq_mask == $past(hwdata[`USBSOF_IRQ_W-1:0]))
      else $error("mask does not follow the write");

   a_mask_read: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_IRQ_MASK && !wr_mask
      |=> hrdata[`USBSOF_IRQ_W-1:0] == $past(irq_mask))
      else $error("mask read wrong");

   // =====================================================================
   // checks of the frame and interrupt side
   a_frame_capture: assert property (
      sof_in.frame_done |=> frm.frame_count_value == $past(sof_in.frame))
      else $error("frame number not captured");

   a_high_upper_zero: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_FRAME_COUNT_VALUE_HI
      |=> hrdata[31:`USBSOF_HI_CRC_GOOD_BIT+1] == '0 && !hrdata[`USBSOF_FRAME_COUNT_VALUE_HI_W])
      else $error("reserved high register bits read as one");

   a_flag_read: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_FRAME_COUNT_VALUE_HI
      |=> hrdata[`USBSOF_HI_CRC_GOOD_BIT] == $past(frm.frame_crc_good)
      && hrdata[`USBSOF_HI_CRC_BAD_BIT] == $past(frm.frame_crc_bad))
      else $error("crc flags read wrong");

   a_set_beats_clear: assert property (
      sof_in.pid_seen |=> irq_stat[`USBSOF_IRQ_SOF_BIT])
      else $error("start of frame event lost");

   a_sof_sticky: assert property (
      irq_stat[`USBSOF_IRQ_SOF_BIT] && !irq_clr[`USBSOF_IRQ_SOF_BIT]
      |=> irq_stat[`USBSOF_IRQ_SOF_BIT])
      else $error("start of frame status dropped");

   a_bad_sticky: assert property (
      irq_stat[`USBSOF_IRQ_CRC_BAD_BIT] && !irq_clr[`USBSOF_IRQ_CRC_BAD_BIT]
      |=> irq_stat[`USBSOF_IRQ_CRC_BAD_BIT])
      else $error("crc bad status dropped");

   a_stat_read_clear: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_IRQ_STAT && !sof_in.pid_seen
      |=> !irq_stat[`USBSOF_IRQ_SOF_BIT])
      else $error("status not cleared by read");

   a_stat_read_value: assert property (
      take_rd && idx_hit && idx == `USBSOF_IDX_IRQ_STAT
      |=> hrdata[`USBSOF_IRQ_W-1:0] == ($past(irq_stat) | $past(irq_set)))
      else $error("status read wrong");

   a_irq_level: assert property (
      irq == |(irq_stat & irq_mask))
      else $error("interrupt level wrong");

endmodule : usbsof_top

// ===== usbsof_defs.svh
// constants of the usb frame number and endpoint fifo reset slice
`ifndef USBSOF_DEFS_SVH
`define USBSOF_DEFS_SVH

// =====================================================================
// register indices (byte address is four times the index)
`define USBSOF_IDX_W 10
`define USBSOF_IDX_FRAME_COUNT_VALUE_LO 10'h0ba
`define USBSOF_IDX_FRAME_COUNT_VALUE_HI 10'h0bb
`define USBSOF_IDX_EP_RST 10'h0d5
`define USBSOF_IDX_IRQ_STAT 10'h0e0
`define USBSOF_IDX_IRQ_MASK 10'h0e1

// =====================================================================
// field positions
`define USBSOF_EP_COUNT 7
`define USBSOF_FRAME_COUNT_VALUE_W 11
`define USBSOF_FRAME_COUNT_VALUE_LO_W 8
`define USBSOF_FRAME_COUNT_VALUE_HI_W 3
`define USBSOF_HI_CRC_GOOD_BIT 5
`define USBSOF_HI_CRC_BAD_BIT 4
`define USBSOF_IRQ_W 2
`define USBSOF_IRQ_SOF_BIT 0
`define USBSOF_IRQ_CRC_BAD_BIT 1

// =====================================================================
// reset values
`define USBSOF_RST_FRAME_COUNT_VALUE 11'h000
`define USBSOF_RST_EP 7'h00
`define USBSOF_RST_IRQ 2'h0

`endif

// ===== usbsof_pkg.sv
// types of the usb frame number and endpoint fifo reset slice
`include "usbsof_defs.svh"

package usbsof_pkg;

   // =====================================================================
   // start of frame events from the packet receiver
   typedef struct packed {
      logic pid_seen;
      logic frame_done;
      logic crc_ok;
      logic [`USBSOF_FRAME_COUNT_VALUE_W-1:0] frame;
   } usbsof_sof_t;

   // =====================================================================
   // captured frame state
   typedef struct packed {
      logic frame_crc_good;
      logic frame_crc_bad;
      logic [`USBSOF_FRAME_COUNT_VALUE_W-1:0] frame_count_value;
   } usbsof_frame_t;

   // =====================================================================
   // pending bus write
   typedef struct packed {
      logic pend;
      logic [`USBSOF_IDX_W-1:0] idx;
   } usbsof_wr_t;

endpackage : usbsof_pkg

// ===== usbsof_host_model.sv
// model of the usb host sending start of frame packets
`timescale 1ns/1ns
module usbsof_host_model (
   // clock
   input wire logic ref_clk,
   // start of frame events
   output usbsof_pkg::usbsof_sof_t sof_in
);
   import usbsof_pkg::*;
   initial sof_in = '0;
   // =====================================================================
   // packet phases
   task automatic send_pid();
      @(posedge ref_clk);
      sof_in.pid_seen <= 1'b1;
      @(posedge ref_clk);
      sof_in.pid_seen <= 1'b0;
   endtask : send_pid
   // frame lines turn over once their cycle is gone
   task automatic send_done(input logic [10:0] f, input logic ok);
      @(posedge ref_clk);
      sof_in.frame_done <= 1'b1;
      sof_in.crc_ok <= ok;
      sof_in.frame <= f;
      @(posedge ref_clk);
      sof_in.frame_done <= 1'b0;
      sof_in.crc_ok <= ~ok;
      sof_in.frame <= ~f;
   endtask : send_done
endmodule : usbsof_host_model

// ===== usb_sof_frame_and_fifo_reset_tb.sv
// self-checking bench of the frame number and fifo reset slice
`timescale 1ns/1ns
module usb_sof_frame_and_fifo_reset_tb;
   import usbsof_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   usbsof_sof_t sof_in;
   logic [6:0] ep_fifo_clear;
   logic irq;
   logic [31:0] rd;
   int n_mismatch = 0;
   int checks_done = 0;
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   usbsof_top usbsof_top_i (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sof_in(sof_in),
      .ep_fifo_clear(ep_fifo_clear), .irq(irq));
   usbsof_host_model usbsof_host_model_i (.ref_clk(ref_clk), .sof_in(sof_in));
   // =====================================================================
   // helpers
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic wait_ready();
      int n;
      n = 0;
      @(posedge ref_clk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 50) begin
            n_mismatch++;
            print_verdict();
         end
         @(posedge ref_clk);
      end
   endtask : wait_ready
   task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {20'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk(hresp, 32'h0, "hresp");
   endtask : bus
   // =====================================================================
   // scenarios
   task automatic t_reset();
      logic [9:0] idx [5] = '{10'h0ba, 10'h0bb, 10'h0d5, 10'h0e0, 10'h0e1};
      foreach (idx[i]) begin
         bus(1'b0, idx[i], 32'h0);
         chk(rd, 32'h0, "reset value");
      end
      chk(ep_fifo_clear, 32'h0, "fifo clear at reset");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_fifo();
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, 10'h0d5, 32'h1 << i);
         #1;
         chk(ep_fifo_clear, 32'h1 << i, "fifo clear out");
         bus(1'b0, 10'h0d5, 32'h0);
         chk(rd, 32'h1 << i, "fifo clear read");
      end
      bus(1'b1, 10'h0d5, 32'hff);
      bus(1'b0, 10'h0d5, 32'h0);
      chk(rd, 32'h7f, "reserved bit");
      bus(1'b1, 10'h0d5, 32'h0);
      $display("t_fifo done");
   endtask : t_fifo
   task automatic t_sof();
      bus(1'b1, 10'h0e1, 32'h3);
      usbsof_host_model_i.send_pid();
      @(posedge ref_clk);
      #1;
      chk(irq, 32'h1, "irq after pid");
      bus(1'b0, 10'h0ba, 32'h0);
      chk(rd, 32'h0, "number before done");
      usbsof_host_model_i.send_done(11'h5a3, 1'b1);
      bus(1'b1, 10'h0bb, 32'hff);
      bus(1'b1, 10'h0ba, 32'h0);
      bus(1'b0, 10'h0bb, 32'h0);
      chk(rd, 32'h25, "high and good flag");
      bus(1'b0, 10'h0ba, 32'h0);
      chk(rd, 32'ha3, "low number held");
      bus(1'b0, 10'h0e0, 32'h0);
      chk(rd, 32'h1, "status pid");
      bus(1'b0, 10'h0e0, 32'h0);
      chk(rd, 32'h0, "status cleared");
      chk(irq, 32'h0, "irq after clear");
      usbsof_host_model_i.send_pid();
      bus(1'b0, 10'h0ba, 32'h0);
      chk(rd, 32'ha3, "number held after pid");
      usbsof_host_model_i.send_done(11'h7ff, 1'b0);
      bus(1'b0, 10'h0bb, 32'h0);
      chk(rd, 32'h17, "bad flag");
      bus(1'b0, 10'h0ba, 32'h0);
      chk(rd, 32'hff, "low number");
      bus(1'b0, 10'h0e0, 32'h0);
      chk(rd, 32'h3, "status bad");
      usbsof_host_model_i.send_pid();
      usbsof_host_model_i.send_done(11'h001, 1'b1);
      bus(1'b0, 10'h0bb, 32'h0);
      chk(rd, 32'h20, "flags refreshed");
      bus(1'b0, 10'h0e0, 32'h0);
      $display("t_sof done");
   endtask : t_sof
   task automatic t_mask();
      bus(1'b1, 10'h0e1, 32'h0);
      usbsof_host_model_i.send_pid();
      repeat (3) @(posedge ref_clk);
      #1;
      chk(irq, 32'h0, "masked irq");
      bus(1'b0, 10'h0e0, 32'h0);
      chk(rd, 32'h1, "status while masked");
      bus(1'b0, 10'h100, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      $display("t_mask done");
   endtask : t_mask
   task automatic t_rereset();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      bus(1'b0, 10'h0ba, 32'h0);
      chk(rd, 32'h0, "low after reset");
      bus(1'b0, 10'h0bb, 32'h0);
      chk(rd, 32'h0, "high after reset");
      $display("t_rereset done");
   endtask : t_rereset
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_fifo();
      t_sof();
      t_mask();
      t_rereset();
      print_verdict();
   end
endmodule : usb_sof_frame_and_fifo_reset_tb
